// ### design/addr_dec_pkg.sv
/*
  Constants, target codes and carrier structs for the local bus address decoder.
  Assumes a single local bus clock domain and 32-bit byte addresses.
*/

package addr_dec_pkg;

  localparam int ADDR_W = 32;

  localparam logic [3:0] TOP_A32D16  = 4'hD;
  localparam logic [3:0] TOP_LOW_MAX = 4'hC;
  localparam logic [3:0] TOP_E       = 4'hE;
  localparam logic [3:0] TOP_F       = 4'hF;

  localparam logic [3:0] SUB_EPROM   = 4'h8;
  localparam logic [3:0] SUB_SRAM    = 4'h9;
  localparam logic [3:0] SUB_A24D32  = 4'hD;
  localparam logic [3:0] SUB_A24D16  = 4'hE;
  localparam logic [3:0] SUB_IO      = 4'hF;

  localparam logic [3:0] IO_SCSI     = 4'h0;
  localparam logic [3:0] IO_LAN      = 4'h1;
  localparam logic [3:0] IO_INTC     = 4'h2;
  localparam logic [3:0] IO_IPCTL    = 4'h3;
  localparam logic [3:0] IO_SLVCTL   = 4'h4;
  localparam logic [3:0] IO_CFGSW    = 4'h5;
  localparam logic [3:0] IO_IPIO     = 4'h8;
  localparam logic [3:0] IO_RTC      = 4'h9;
  localparam logic [3:0] IO_PAR      = 4'hA;
  localparam logic [3:0] IO_SCC      = 4'hB;
  localparam logic [3:0] IO_A16D32   = 4'hE;
  localparam logic [3:0] IO_A16D16   = 4'hF;

  localparam logic [31:0] SRAM_SMALL_BYTES = 32'h0008_0000;
  localparam logic [31:0] SRAM_LARGE_BYTES = 32'h0020_0000;
  localparam logic [31:0] LOW_ONBOARD_TOP  = 32'h1000_0000;
  localparam logic [1:0]  BOOT_ALIAS_COUNT = 2'h2;
  localparam logic [15:0] A16_WRAP_MASK    = 16'hFFFF;

  localparam int    CLK_MHZ        = 25;
  localparam int    BUS_TIMEOUT_NS = 2000;
  localparam int    BUS_TIMEOUT_CYC = (BUS_TIMEOUT_NS * CLK_MHZ) / 1000;

  typedef enum logic [4:0] {
    TGT_NONE, TGT_MODULE, TGT_SRAM, TGT_EPROM, TGT_IPMEM,
    TGT_VME_A32D32, TGT_VME_A32D16, TGT_VME_A24D32, TGT_VME_A24D16,
    TGT_VME_A16D32, TGT_VME_A16D16,
    TGT_SCSI, TGT_LAN, TGT_INTC, TGT_IPCTL, TGT_SLVCTL, TGT_CFGSW,
    TGT_IPIO, TGT_RTC, TGT_PAR, TGT_SCC
  } target_t;

  typedef struct packed {
    logic        start;
    logic [31:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    target_t     target;
    logic [31:0] offset;
    logic        boot_alias;
  } select_t;

endpackage

// ### design/cycle_watchdog.sv
/*
  Bus cycle watchdog: ends an access that nobody answers with a bus error.
  Assumes start and done are single-cycle pulses on the local bus clock.
*/
`timescale 1ns/1ns
`default_nettype none

module cycle_watchdog #(
  parameter int TIMEOUT_CYC = addr_dec_pkg::BUS_TIMEOUT_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic no_target,
  input  wire logic done,
  output logic      bus_err
);

  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic        err;
  } wd_state_t;

  wd_state_t st_reg;
  wd_state_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.err = 1'b0;
    if (start && no_target) begin
      st_next.err  = 1'b1;
      st_next.busy = 1'b0;
    end else if (start) begin
      st_next.busy = 1'b1;
      st_next.cnt  = 16'h0000;
    end else if (st_reg.busy) begin
      if (done) begin
        st_next.busy = 1'b0;
      end else if (st_reg.cnt == 16'(TIMEOUT_CYC - 1)) begin
        st_next.err  = 1'b1;
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign bus_err = st_reg.err;

  unclaimed_err_a: assert property (@(posedge mclk) disable iff (rst)
    ce && start && no_target |=> bus_err) else $error("Unclaimed access got no bus error.");

endmodule

`default_nettype wire

// ### design/local_bus_address_decoder.sv
/*
  Local bus address decoder: maps each 32-bit byte address to one target.
  Assumes the arbiter presents one master's access at a time on this port, and that
  module_present_n comes from the memory module in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module local_bus_address_decoder #(
  parameter int TIMEOUT_CYC = addr_dec_pkg::BUS_TIMEOUT_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire addr_dec_pkg::bus_req_t req,
  input  wire logic                  module_present_n,
  input  wire logic                  sram_low_map,
  input  wire logic                  vme_low_window,
  input  wire logic                  sram_large,
  input  wire logic                  cycle_done,
  output addr_dec_pkg::select_t      sel,
  output logic                       bus_err
);

  typedef struct packed {
    addr_dec_pkg::select_t sel;
    logic [1:0]            boot_cnt;
  } dec_state_t;

  dec_state_t st_reg;
  dec_state_t st_next;

  // Strap inputs come from pins and pass two flip-flops first.
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic       low_map_s;
  logic       vme_low_s;
  logic       large_s;

  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
    end else if (ce) begin
      strap_meta_reg <= {sram_large, vme_low_window, sram_low_map};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign low_map_s = strap_sync_reg[0];
  assign vme_low_s = strap_sync_reg[1];
  assign large_s   = strap_sync_reg[2];

  // I/O page decode from address bits 23:20 alone; the select carries no cache attribute.
  function automatic addr_dec_pkg::target_t io_target(input logic [31:0] a);
    case (a[23:20])
      addr_dec_pkg::IO_SCSI:   io_target = addr_dec_pkg::TGT_SCSI;
      addr_dec_pkg::IO_LAN:    io_target = addr_dec_pkg::TGT_LAN;
      addr_dec_pkg::IO_INTC:   io_target = addr_dec_pkg::TGT_INTC;
      addr_dec_pkg::IO_IPCTL:  io_target = addr_dec_pkg::TGT_IPCTL;
      addr_dec_pkg::IO_SLVCTL: io_target = addr_dec_pkg::TGT_SLVCTL;
      addr_dec_pkg::IO_CFGSW:  io_target = addr_dec_pkg::TGT_CFGSW;
      addr_dec_pkg::IO_IPIO:   io_target = addr_dec_pkg::TGT_IPIO;
      addr_dec_pkg::IO_RTC:    io_target = addr_dec_pkg::TGT_RTC;
      addr_dec_pkg::IO_PAR:    io_target = addr_dec_pkg::TGT_PAR;
      addr_dec_pkg::IO_SCC:    io_target = addr_dec_pkg::TGT_SCC;
      addr_dec_pkg::IO_A16D32: io_target = addr_dec_pkg::TGT_VME_A16D32;
      addr_dec_pkg::IO_A16D16: io_target = addr_dec_pkg::TGT_VME_A16D16;
      default:                 io_target = addr_dec_pkg::TGT_NONE;
    endcase
  endfunction

  // Upper E and F halves mirror each other apart from the F-only I/O page.
  function automatic addr_dec_pkg::target_t hi_target(input logic [31:0] a);
    if (a[27] == 1'b0) begin
      hi_target = addr_dec_pkg::TGT_IPMEM;
    end else begin
      case (a[27:24])
        addr_dec_pkg::SUB_EPROM:  hi_target = addr_dec_pkg::TGT_EPROM;
        addr_dec_pkg::SUB_SRAM:   hi_target = addr_dec_pkg::TGT_SRAM;
        addr_dec_pkg::SUB_A24D32: hi_target = addr_dec_pkg::TGT_VME_A24D32;
        addr_dec_pkg::SUB_A24D16: hi_target = addr_dec_pkg::TGT_VME_A24D16;
        addr_dec_pkg::SUB_IO: begin
          if (a[31:28] == addr_dec_pkg::TOP_F) begin
            hi_target = io_target(a);
          end else begin
            hi_target = addr_dec_pkg::TGT_NONE;
          end
        end
        default: hi_target = addr_dec_pkg::TGT_NONE;
      endcase
    end
  endfunction

  logic [31:0]           sram_top;
  addr_dec_pkg::target_t tgt;
  logic [31:0]           offs;
  logic                  alias_on;

  assign sram_top = large_s ? addr_dec_pkg::SRAM_LARGE_BYTES : addr_dec_pkg::SRAM_SMALL_BYTES;
  assign alias_on = st_reg.boot_cnt != addr_dec_pkg::BOOT_ALIAS_COUNT;

  always_comb begin
    tgt  = addr_dec_pkg::TGT_NONE;
    offs = req.addr;
    if (req.addr[31:28] <= addr_dec_pkg::TOP_LOW_MAX) begin
      if (alias_on && req.addr < addr_dec_pkg::SRAM_LARGE_BYTES) begin
        tgt = addr_dec_pkg::TGT_EPROM;
      end else if (low_map_s && req.addr < sram_top) begin
        tgt = addr_dec_pkg::TGT_SRAM;
      end else if (!module_present_n) begin
        tgt = addr_dec_pkg::TGT_MODULE;
      end else if (!vme_low_s && req.addr < addr_dec_pkg::LOW_ONBOARD_TOP) begin
        tgt = addr_dec_pkg::TGT_NONE;
      end else begin
        tgt = addr_dec_pkg::TGT_VME_A32D32;
      end
    end else if (req.addr[31:28] == addr_dec_pkg::TOP_A32D16) begin
      tgt = addr_dec_pkg::TGT_VME_A32D16;
    end else begin
      tgt = hi_target(req.addr);
    end
    if (tgt == addr_dec_pkg::TGT_VME_A16D32 || tgt == addr_dec_pkg::TGT_VME_A16D16) begin
      offs = {16'h0000, req.addr[15:0] & addr_dec_pkg::A16_WRAP_MASK};
    end
  end

  always_comb begin
    st_next           = st_reg;
    st_next.sel.valid = 1'b0;
    if (req.start) begin
      st_next.sel.valid      = 1'b1;
      st_next.sel.target     = tgt;
      st_next.sel.offset     = offs;
      st_next.sel.boot_alias = alias_on && tgt == addr_dec_pkg::TGT_EPROM
                               && req.addr[31:28] == 4'h0;
      if (alias_on) begin
        st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign sel = st_reg.sel;

  // The module path is fixed at 32 bits; burst timing is the module's own.
  cycle_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) cycle_watchdog_inst (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .start     (req.start),
    .no_target (tgt == addr_dec_pkg::TGT_NONE),
    .done      (cycle_done),
    .bus_err   (bus_err)
  );

  boot_alias_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && alias_on && req.addr == 32'h0000_0000
    |=> sel.valid && sel.target == addr_dec_pkg::TGT_EPROM) else $error("Boot alias missing.");
  alias_stop_a: assert property (@(posedge mclk) disable iff (rst)
    st_reg.boot_cnt != 2'h3) else $error("Boot alias counter overran.");
  sram_alt_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && (req.addr[31:24] == 8'hE9 || req.addr[31:24] == 8'hF9)
    |=> sel.target == addr_dec_pkg::TGT_SRAM) else $error("SRAM alternate window lost.");
  eprom_dual_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && (req.addr[31:24] == 8'hE8 || req.addr[31:24] == 8'hF8)
    |=> sel.target == addr_dec_pkg::TGT_EPROM) else $error("EPROM window misdecoded.");
  low_sram_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && !alias_on && low_map_s && req.addr < sram_top
    |=> sel.target == addr_dec_pkg::TGT_SRAM) else $error("Low SRAM not selected.");
  no_vme_low_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && !vme_low_s && req.addr < addr_dec_pkg::LOW_ONBOARD_TOP
    |=> sel.target != addr_dec_pkg::TGT_VME_A32D32) else $error("VMEbus reached in low 256Mb.");
  a32_fill_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && !alias_on && !low_map_s && module_present_n && vme_low_s
    && req.addr[31:28] <= 4'hC |=> sel.target == addr_dec_pkg::TGT_VME_A32D32)
    else $error("Low gap not sent to A32:D32.");
  a16_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:20] == 12'hFFE
    |=> sel.target == addr_dec_pkg::TGT_VME_A16D32 && sel.offset[31:16] == 16'h0000)
    else $error("A16 D32 window misdecoded.");
  module_sel_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && !alias_on && !module_present_n && !low_map_s && req.addr[31:28] <= 4'hC
    |=> sel.target == addr_dec_pkg::TGT_MODULE) else $error("Module claim ignored.");

  // Every taken start gives one valid cycle; a cycle with ce high and no start gives none.
  valid_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start |=> sel.valid) else $error("Select valid missing after start.");
  valid_idle_a: assert property (@(posedge mclk) disable iff (rst)
    ce && !req.start |=> !sel.valid) else $error("Select valid without start.");
  a32_d16_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:28] == addr_dec_pkg::TOP_A32D16
    |=> sel.target == addr_dec_pkg::TGT_VME_A32D16) else $error("A32 D16 window misdecoded.");
  ipmem_dual_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:29] == 3'h7 && req.addr[27] == 1'b0
    |=> sel.target == addr_dec_pkg::TGT_IPMEM) else $error("IP memory window misdecoded.");
  a24_d32_dual_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:29] == 3'h7 && req.addr[27:24] == addr_dec_pkg::SUB_A24D32
    |=> sel.target == addr_dec_pkg::TGT_VME_A24D32) else $error("A24 D32 window misdecoded.");
  a24_d16_dual_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:29] == 3'h7 && req.addr[27:24] == addr_dec_pkg::SUB_A24D16
    |=> sel.target == addr_dec_pkg::TGT_VME_A24D16) else $error("A24 D16 window misdecoded.");
  a16_d16_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:20] == 12'hFFF
    |=> sel.target == addr_dec_pkg::TGT_VME_A16D16
    && sel.offset == {16'h0000, $past(req.addr[15:0])})
    else $error("A16 D16 window misdecoded.");
  reserved_none_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && req.addr[31:24] inside {8'hEA, 8'hEB, 8'hEC, 8'hEF, 8'hFA, 8'hFB, 8'hFC}
    |=> sel.target == addr_dec_pkg::TGT_NONE) else $error("Reserved range was claimed.");
  alias_over_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && !alias_on && req.addr < addr_dec_pkg::SRAM_LARGE_BYTES
    |=> !sel.boot_alias && sel.target != addr_dec_pkg::TGT_EPROM)
    else $error("Boot alias outlived two accesses.");
  module_path_a: assert property (@(posedge mclk) disable iff (rst)
    ce && req.start && tgt == addr_dec_pkg::TGT_MODULE
    |=> sel.offset == $past(req.addr)) else $error("Module access lost address bits.");

endmodule

`default_nettype wire

// ### bench/bus_partner.sv
/*
  Memory module and target model on the far side of the address decoder.
  Assumes the decoder's request and select carriers and one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_partner #(
  parameter logic [31:0] MOD_BYTES = 32'h0100_0000
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  stall,
  input  wire addr_dec_pkg::bus_req_t req,
  input  wire addr_dec_pkg::select_t  sel,
  output logic                       module_present_n,
  output logic                       cycle_done
);
  // The module claims only addresses it holds, and only in the start cycle.
  assign module_present_n = !(req.start && (req.addr < MOD_BYTES));

  // Claimed accesses end one cycle after the select unless stalled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= sel.valid && (sel.target != addr_dec_pkg::TGT_NONE) && !stall;
    end
  end
endmodule

`default_nettype wire

// ### bench/local_bus_address_decoder_bench.sv
/*
  Self-checking bench for the local bus address decoder.
  Assumes bus_partner as memory module and a 25 MHz mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module local_bus_address_decoder_bench;
  localparam int TO = 8;
  logic                   mclk  = 1'b0;
  logic                   rst   = 1'b1;
  logic                   ce    = 1'b1;
  logic                   srlo  = 1'b0;
  logic                   vlo   = 1'b1;
  logic                   slg   = 1'b0;
  logic                   stall = 1'b0;
  logic                   mod_n;
  logic                   done;
  logic                   berr;
  addr_dec_pkg::bus_req_t req   = '0;
  addr_dec_pkg::select_t  sel;
  int                     fails = 0;
  int                     checks = 0;

  always #20 mclk = ~mclk;

  local_bus_address_decoder #(.TIMEOUT_CYC(TO)) local_bus_address_decoder_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .req(req), .module_present_n(mod_n),
    .sram_low_map(srlo), .vme_low_window(vlo), .sram_large(slg),
    .cycle_done(done), .sel(sel), .bus_err(berr));

  bus_partner bus_partner_inst (
    .mclk(mclk), .rst(rst), .stall(stall), .req(req), .sel(sel),
    .module_present_n(mod_n), .cycle_done(done));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One access; the select is judged in the cycle after the start.
  task automatic acc(input logic [31:0] a, input addr_dec_pkg::target_t t,
                     input logic [31:0] off, input logic ba);
    @(posedge mclk);
    req <= '{start: 1'b1, addr: a};
    @(posedge mclk);
    req.start <= 1'b0;
    #1;
    check({31'h0, sel.valid}, 32'h1);
    check({27'h0, sel.target}, {27'h0, t});
    check(sel.offset, off);
    check({31'h0, sel.boot_alias}, {31'h0, ba});
    check({31'h0, berr}, {31'h0, t == addr_dec_pkg::TGT_NONE});
  endtask

  task automatic t_boot;
    acc(32'h0000_0000, addr_dec_pkg::TGT_EPROM, 32'h0000_0000, 1'b1);
    acc(32'h0000_0004, addr_dec_pkg::TGT_EPROM, 32'h0000_0004, 1'b1);
    acc(32'h0000_0000, addr_dec_pkg::TGT_MODULE, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_windows;
    acc(32'hE000_0000, addr_dec_pkg::TGT_IPMEM, 32'hE000_0000, 1'b0);
    acc(32'hF000_0000, addr_dec_pkg::TGT_IPMEM, 32'hF000_0000, 1'b0);
    acc(32'hE800_0000, addr_dec_pkg::TGT_EPROM, 32'hE800_0000, 1'b0);
    acc(32'hF800_0000, addr_dec_pkg::TGT_EPROM, 32'hF800_0000, 1'b0);
    acc(32'hE900_0000, addr_dec_pkg::TGT_SRAM, 32'hE900_0000, 1'b0);
    acc(32'hF900_0000, addr_dec_pkg::TGT_SRAM, 32'hF900_0000, 1'b0);
    acc(32'hED00_0000, addr_dec_pkg::TGT_VME_A24D32, 32'hED00_0000, 1'b0);
    acc(32'hFD00_0000, addr_dec_pkg::TGT_VME_A24D32, 32'hFD00_0000, 1'b0);
    acc(32'hEE00_0000, addr_dec_pkg::TGT_VME_A24D16, 32'hEE00_0000, 1'b0);
    acc(32'hFE00_0000, addr_dec_pkg::TGT_VME_A24D16, 32'hFE00_0000, 1'b0);
    acc(32'hD000_0000, addr_dec_pkg::TGT_VME_A32D16, 32'hD000_0000, 1'b0);
    acc(32'hFF10_0000, addr_dec_pkg::TGT_LAN, 32'hFF10_0000, 1'b0);
    acc(32'hFF00_0000, addr_dec_pkg::TGT_SCSI, 32'hFF00_0000, 1'b0);
    acc(32'hFF20_0000, addr_dec_pkg::TGT_INTC, 32'hFF20_0000, 1'b0);
    acc(32'hFF30_0000, addr_dec_pkg::TGT_IPCTL, 32'hFF30_0000, 1'b0);
    acc(32'hFF40_0000, addr_dec_pkg::TGT_SLVCTL, 32'hFF40_0000, 1'b0);
    acc(32'hFF5F_FFFF, addr_dec_pkg::TGT_CFGSW, 32'hFF5F_FFFF, 1'b0);
    acc(32'hFF80_0000, addr_dec_pkg::TGT_IPIO, 32'hFF80_0000, 1'b0);
    acc(32'hFF90_0000, addr_dec_pkg::TGT_RTC, 32'hFF90_0000, 1'b0);
    acc(32'hFFA0_0000, addr_dec_pkg::TGT_PAR, 32'hFFA0_0000, 1'b0);
    acc(32'hFFB0_0000, addr_dec_pkg::TGT_SCC, 32'hFFB0_0000, 1'b0);
    acc(32'hDFFF_FFFF, addr_dec_pkg::TGT_VME_A32D16, 32'hDFFF_FFFF, 1'b0);
    acc(32'hE7FF_FFFC, addr_dec_pkg::TGT_IPMEM, 32'hE7FF_FFFC, 1'b0);
    acc(32'hFFEF_5678, addr_dec_pkg::TGT_VME_A16D32, 32'h0000_5678, 1'b0);
    acc(32'hFFD0_0000, addr_dec_pkg::TGT_NONE, 32'hFFD0_0000, 1'b0);
    acc(32'hFA00_0000, addr_dec_pkg::TGT_NONE, 32'hFA00_0000, 1'b0);
    acc(32'hFFE0_1234, addr_dec_pkg::TGT_VME_A16D32, 32'h0000_1234, 1'b0);
    acc(32'hFFF5_ABCD, addr_dec_pkg::TGT_VME_A16D16, 32'h0000_ABCD, 1'b0);
    acc(32'hEA00_0000, addr_dec_pkg::TGT_NONE, 32'hEA00_0000, 1'b0);
    acc(32'hEF00_0000, addr_dec_pkg::TGT_NONE, 32'hEF00_0000, 1'b0);
    acc(32'hFF60_0000, addr_dec_pkg::TGT_NONE, 32'hFF60_0000, 1'b0);
    acc(32'hC000_0000, addr_dec_pkg::TGT_VME_A32D32, 32'hC000_0000, 1'b0);
  endtask

  task automatic t_low_sram;
    srlo <= 1'b1;
    idle(4);
    acc(32'h0007_FFFC, addr_dec_pkg::TGT_SRAM, 32'h0007_FFFC, 1'b0);
    acc(32'h0008_0000, addr_dec_pkg::TGT_MODULE, 32'h0008_0000, 1'b0);
    acc(32'hE900_0010, addr_dec_pkg::TGT_SRAM, 32'hE900_0010, 1'b0);
    slg <= 1'b1;
    idle(4);
    acc(32'h001F_FFFC, addr_dec_pkg::TGT_SRAM, 32'h001F_FFFC, 1'b0);
    acc(32'h0020_0000, addr_dec_pkg::TGT_MODULE, 32'h0020_0000, 1'b0);
    srlo <= 1'b0;
    slg  <= 1'b0;
    idle(4);
  endtask

  task automatic t_vme_low;
    vlo <= 1'b0;
    idle(4);
    acc(32'h0F00_0000, addr_dec_pkg::TGT_NONE, 32'h0F00_0000, 1'b0);
    acc(32'h1000_0000, addr_dec_pkg::TGT_VME_A32D32, 32'h1000_0000, 1'b0);
    acc(32'h0000_1000, addr_dec_pkg::TGT_MODULE, 32'h0000_1000, 1'b0);
    vlo <= 1'b1;
    idle(4);
    acc(32'h0200_0000, addr_dec_pkg::TGT_VME_A32D32, 32'h0200_0000, 1'b0);
  endtask

  // An unanswered access must end in a bus error after the watchdog period.
  task automatic t_timeout;
    int n;
    n = 1;
    stall <= 1'b1;
    acc(32'h2000_0000, addr_dec_pkg::TGT_VME_A32D32, 32'h2000_0000, 1'b0);
    while (berr !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(n, TO + 1);
    if (n == 40) end_sim();
    stall <= 1'b0;
    idle(2);
  endtask

  // With ce low a start is not taken and the select keeps its last target.
  task automatic t_freeze;
    @(posedge mclk);
    ce  <= 1'b0;
    req <= '{start: 1'b1, addr: 32'hE800_0000};
    @(posedge mclk);
    req.start <= 1'b0;
    #1;
    check({31'h0, sel.valid}, 32'h0);
    check({27'h0, sel.target}, {27'h0, addr_dec_pkg::TGT_VME_A32D32});
    check({31'h0, berr}, 32'h0);
    @(posedge mclk);
    ce <= 1'b1;
    idle(2);
  endtask

  // A second reset re-arms the boot alias for two accesses of any kind.
  task automatic t_rerun;
    @(posedge mclk);
    rst <= 1'b1;
    idle(5);
    rst <= 1'b0;
    check({27'h0, sel.target}, {27'h0, addr_dec_pkg::TGT_NONE});
    check({31'h0, sel.valid}, 32'h0);
    acc(32'hF800_0000, addr_dec_pkg::TGT_EPROM, 32'hF800_0000, 1'b0);
    acc(32'h0000_0008, addr_dec_pkg::TGT_EPROM, 32'h0000_0008, 1'b1);
    acc(32'h0000_0008, addr_dec_pkg::TGT_MODULE, 32'h0000_0008, 1'b0);
  endtask

  initial begin
    idle(5);
    rst <= 1'b0;
    t_boot();
    t_windows();
    t_low_sram();
    t_vme_low();
    t_timeout();
    t_freeze();
    t_rerun();
    end_sim();
  end
endmodule

`default_nettype wire
